// ### pkg/lic_pkg.sv
// Functional notes
// - Third indicator select code, resets to receive
// - Codes force on, off, fast or slow blink
// - Combined displays; codes 0110, 1111 show nothing
// - Stretch duration 30, 60, 100 ms; resets 00
// - Stretch enable bit governs all but combined displays, resets 1
// - Combined displays always stretched
// - Link steady on, receive or activity toggles
// - Activity blinks even with link down
// - Full duplex steady on, collision toggles
// - Lowest config bit reserved, reads and resets zero
// - First and second selects; reset speed, link
// - Levels continuous; transmit, receive, collision, activity stretched
package lic_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned STR0_MS       = 30;
  localparam int unsigned STR1_MS       = 60;
  localparam int unsigned STR2_MS       = 100;
  localparam int unsigned STR0_CYC      = STR0_MS * CYC_PER_MS;
  localparam int unsigned STR1_CYC      = STR1_MS * CYC_PER_MS;
  localparam int unsigned STR2_CYC      = STR2_MS * CYC_PER_MS;
  localparam int unsigned CNT_W         = 23;
  // Blink divider taps: 2^22 cycles is about 84 ms per half period
  localparam int unsigned FAST_BIT      = 22;
  localparam int unsigned SLOW_BIT      = 24;
  localparam int unsigned NUM_IND       = 3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [4:0]  CFG_ADDR      = 5'h14;
  localparam logic [15:0] CFG_RESET     = 16'h0422;
  localparam logic [15:0] CFG_WR_MASK   = 16'hfffe;
  localparam logic [15:0] RD_UNMAPPED   = 16'h0000;

  typedef enum logic [3:0] {
    LIC_SEL_SPEED   = 4'h0,
    LIC_SEL_TX      = 4'h1,
    LIC_SEL_RX      = 4'h2,
    LIC_SEL_COL     = 4'h3,
    LIC_SEL_LINK    = 4'h4,
    LIC_SEL_DUPLEX  = 4'h5,
    LIC_SEL_UNUSED6 = 4'h6,
    LIC_SEL_ACT     = 4'h7,
    LIC_SEL_ON      = 4'h8,
    LIC_SEL_OFF     = 4'h9,
    LIC_SEL_FAST    = 4'ha,
    LIC_SEL_SLOW    = 4'hb,
    LIC_SEL_LINK_RX = 4'hc,
    LIC_SEL_LINK_AC = 4'hd,
    LIC_SEL_DUP_COL = 4'he,
    LIC_SEL_UNUSEDF = 4'hf
  } lic_sel_e;

  typedef enum logic [1:0] {
    LIC_DUR_30  = 2'h0,
    LIC_DUR_60  = 2'h1,
    LIC_DUR_100 = 2'h2,
    LIC_DUR_RSV = 2'h3
  } lic_dur_e;

  // Field layout of the configuration word, msb first
  typedef struct packed {
    lic_sel_e sel1;
    lic_sel_e sel2;
    lic_sel_e sel3;
    lic_dur_e dur;
    logic     stretch_en;
    logic     rsvd0;
  } lic_cfg_s;

  typedef struct packed {
    logic speed;
    logic link;
    logic duplex;
    logic tx;
    logic rx;
    logic col;
  } lic_status_s;

  typedef struct packed {
    logic lvl;
    logic evt;
    logic is_event;
    logic combined;
  } lic_src_s;

endpackage

// ### verilog/lic_stretch.sv
`timescale 1ns/10ps
module lic_stretch #(
  parameter int unsigned CNT_W = lic_pkg::CNT_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             evt,
  input  wire logic             en,
  input  wire logic [CNT_W-1:0] dur_cyc,
  output logic                  active
);

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // ---------------------------------------------------------------
  // Retriggerable hold counter
  // ---------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    if (!en) begin
      cnt_nxt = '0;
    end else if (evt) begin
      cnt_nxt = dur_cyc;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Raw event passes through when stretching is off
  assign active = evt | (en & (cnt_r != '0));

endmodule

// ### verilog/lic_top.sv
`timescale 1ns/10ps
module lic_top #(
  parameter int unsigned STR0_CYC = lic_pkg::STR0_CYC,
  parameter int unsigned STR1_CYC = lic_pkg::STR1_CYC,
  parameter int unsigned STR2_CYC = lic_pkg::STR2_CYC,
  parameter int unsigned FAST_BIT = lic_pkg::FAST_BIT,
  parameter int unsigned SLOW_BIT = lic_pkg::SLOW_BIT
) (
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic [4:0]                   mgmt_addr,
  input  wire logic                         mgmt_wr_en,
  input  wire logic [15:0]                  mgmt_wdata,
  output logic      [15:0]                  mgmt_rdata,
  input  wire lic_pkg::lic_status_s         status,
  output logic      [lic_pkg::NUM_IND-1:0]  ind_on
);

  localparam int unsigned CNT_W = lic_pkg::CNT_W;
  localparam int unsigned NI    = lic_pkg::NUM_IND;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (STR0_CYC == 0 || STR1_CYC == 0 || STR2_CYC == 0) begin : g_chk_zero
    $error("Stretch durations must be at least one cycle");
  end
  if (STR0_CYC >= (64'd1 << CNT_W) || STR1_CYC >= (64'd1 << CNT_W) ||
      STR2_CYC >= (64'd1 << CNT_W)) begin : g_chk_wide
    $error("Stretch duration exceeds counter width");
  end
  if (FAST_BIT >= SLOW_BIT) begin : g_chk_blink
    $error("Slow blink tap must be above fast blink tap");
  end

  // ---------------------------------------------------------------
  // Configuration register
  // ---------------------------------------------------------------
  lic_pkg::lic_cfg_s cfg_r;
  lic_pkg::lic_cfg_s cfg_nxt;
  logic [15:0]       rdata_r;
  logic [15:0]       rdata_nxt;
  logic              hit;

  assign hit = (mgmt_addr == lic_pkg::CFG_ADDR);

  always_comb begin
    cfg_nxt   = cfg_r;
    rdata_nxt = lic_pkg::RD_UNMAPPED;
    if (mgmt_wr_en && hit) begin
      // Reserved bit dropped so it can never read back as one
      cfg_nxt = lic_pkg::lic_cfg_s'(mgmt_wdata & lic_pkg::CFG_WR_MASK);
    end
    if (hit) begin
      rdata_nxt = cfg_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_r   <= lic_pkg::lic_cfg_s'(lic_pkg::CFG_RESET);
      rdata_r <= lic_pkg::RD_UNMAPPED;
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign mgmt_rdata = rdata_r;

  // ---------------------------------------------------------------
  // Blink timebase
  // ---------------------------------------------------------------
  logic [SLOW_BIT:0] blink_r;
  logic [SLOW_BIT:0] blink_nxt;
  logic              fast_blink;
  logic              slow_blink;

  always_comb begin
    blink_nxt = blink_r + (SLOW_BIT+1)'(1);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      blink_r <= '0;
    end else begin
      blink_r <= blink_nxt;
    end
  end

  assign fast_blink = blink_r[FAST_BIT];
  assign slow_blink = blink_r[SLOW_BIT];

  // ---------------------------------------------------------------
  // Stretch duration choice
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] dur_cyc;

  always_comb begin
    case (cfg_r.dur)
      lic_pkg::LIC_DUR_30:  dur_cyc = CNT_W'(STR0_CYC);
      lic_pkg::LIC_DUR_60:  dur_cyc = CNT_W'(STR1_CYC);
      lic_pkg::LIC_DUR_100: dur_cyc = CNT_W'(STR2_CYC);
      // Reserved code: longest hold, the safest visible choice
      default:              dur_cyc = CNT_W'(STR2_CYC);
    endcase
  end

  // ---------------------------------------------------------------
  // Source decode
  // ---------------------------------------------------------------
  function automatic lic_pkg::lic_src_s pick(
    input lic_pkg::lic_sel_e    sel,
    input lic_pkg::lic_status_s st,
    input logic                 fast,
    input logic                 slow
  );
    lic_pkg::lic_src_s s;
    s = '0;
    case (sel)
      lic_pkg::LIC_SEL_SPEED: begin
        s.lvl = st.speed;
      end
      lic_pkg::LIC_SEL_TX: begin
        s.evt      = st.tx;
        s.is_event = 1'b1;
      end
      lic_pkg::LIC_SEL_RX: begin
        s.evt      = st.rx;
        s.is_event = 1'b1;
      end
      lic_pkg::LIC_SEL_COL: begin
        s.evt      = st.col;
        s.is_event = 1'b1;
      end
      lic_pkg::LIC_SEL_LINK: begin
        s.lvl = st.link;
      end
      lic_pkg::LIC_SEL_DUPLEX: begin
        s.lvl = st.duplex;
      end
      lic_pkg::LIC_SEL_ACT: begin
        s.evt      = st.rx | st.tx;
        s.is_event = 1'b1;
      end
      lic_pkg::LIC_SEL_ON: begin
        s.lvl = 1'b1;
      end
      lic_pkg::LIC_SEL_OFF: begin
        s.lvl = 1'b0;
      end
      lic_pkg::LIC_SEL_FAST: begin
        s.lvl = fast;
      end
      lic_pkg::LIC_SEL_SLOW: begin
        s.lvl = slow;
      end
      lic_pkg::LIC_SEL_LINK_RX: begin
        s.lvl      = st.link;
        s.evt      = st.rx;
        s.combined = 1'b1;
      end
      lic_pkg::LIC_SEL_LINK_AC: begin
        // Activity alone still toggles a dark lamp
        s.lvl      = st.link;
        s.evt      = st.rx | st.tx;
        s.combined = 1'b1;
      end
      lic_pkg::LIC_SEL_DUP_COL: begin
        s.lvl      = st.duplex;
        s.evt      = st.col;
        s.combined = 1'b1;
      end
      default: begin
        s = '0;
      end
    endcase
    return s;
  endfunction

  // ---------------------------------------------------------------
  // Indicator channels
  // ---------------------------------------------------------------
  lic_pkg::lic_sel_e sel [NI];
  logic [NI-1:0]     ind_r;
  logic [NI-1:0]     ind_nxt;

  assign sel[0] = cfg_r.sel1;
  assign sel[1] = cfg_r.sel2;
  assign sel[2] = cfg_r.sel3;

  for (genvar i = 0; i < NI; i++) begin : g_ind
    lic_pkg::lic_src_s src;
    logic              hold_en;
    logic              active;

    assign src = pick(sel[i], status, fast_blink, slow_blink);
    // Combined displays ignore the global stretch enable
    assign hold_en = cfg_r.stretch_en | src.combined;

    lic_stretch #(
      .CNT_W   (CNT_W)
    ) u_stretch (
      .clk_sys (clk_sys),
      .rst     (rst),
      .evt     (src.evt),
      .en      (hold_en),
      .dur_cyc (dur_cyc),
      .active  (active)
    );

    always_comb begin
      if (src.combined) begin
        ind_nxt[i] = src.lvl ^ active;
      end else if (src.is_event) begin
        ind_nxt[i] = active;
      end else begin
        ind_nxt[i] = src.lvl;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ind_r <= '0;
    end else begin
      ind_r <= ind_nxt;
    end
  end

  assign ind_on = ind_r;

endmodule

// ### sim/lic_top_properties.sv
`timescale 1ns/10ps
module lic_chk #(
  parameter int unsigned STR0_CYC = lic_pkg::STR0_CYC,
  parameter int unsigned STR1_CYC = lic_pkg::STR1_CYC,
  parameter int unsigned STR2_CYC = lic_pkg::STR2_CYC
) (
  input wire logic                        clk_sys,
  input wire logic                        rst,
  input wire logic [4:0]                  mgmt_addr,
  input wire logic                        mgmt_wr_en,
  input wire logic [15:0]                 mgmt_wdata,
  input wire logic [15:0]                 mgmt_rdata,
  input wire lic_pkg::lic_status_s        status,
  input wire logic [lic_pkg::NUM_IND-1:0] ind_on
);
  logic [15:0]       cfg_r, cfg_nxt;
  logic [7:0]        gap_r, gap_nxt;
  lic_pkg::lic_cfg_s cfg_v;
  int unsigned       dur_c;
  logic              rx3;
  // ------------------------------------------
  // Shadow config, cycles since receive event
  // ------------------------------------------
  // A write voids the gap so a hold is only judged under one setting
  always_comb begin
    cfg_nxt = cfg_r;
    gap_nxt = (gap_r != 8'h00 && gap_r != 8'hff) ? gap_r + 8'h01 : gap_r;
    if (status.rx) begin
      gap_nxt = 8'h01;
    end
    if (mgmt_wr_en && mgmt_addr == 5'h14) begin
      cfg_nxt = mgmt_wdata & 16'hfffe;
      gap_nxt = 8'h00;
    end
  end
  always_ff @(posedge clk_sys) begin
    cfg_r <= rst ? 16'h0422 : cfg_nxt;
    gap_r <= rst ? 8'h00 : gap_nxt;
  end
  assign cfg_v = lic_pkg::lic_cfg_s'(cfg_r);
  assign dur_c = cfg_v.dur == lic_pkg::LIC_DUR_30 ? STR0_CYC :
                 cfg_v.dur == lic_pkg::LIC_DUR_60 ? STR1_CYC : STR2_CYC;
  assign rx3 = cfg_v.sel3 == lic_pkg::LIC_SEL_RX && cfg_v.stretch_en;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_rx_evt;
    cfg_v.sel3 == lic_pkg::LIC_SEL_RX && status.rx;
  endsequence
  a_rd_cfg: assert property (
    mgmt_addr == 5'h14 |=> mgmt_rdata == $past(cfg_r)) else $error("config read wrong");
  a_rd_other: assert property (
    mgmt_addr != 5'h14 |=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rsv_bit: assert property (
    mgmt_wr_en && mgmt_wdata[0] |-> ##2 !mgmt_rdata[0]) else $error("reserved bit set");
  a_force_on: assert property (
    cfg_v.sel3 == lic_pkg::LIC_SEL_ON |=> ind_on[2]) else $error("forced on lamp dark");
  a_force_off: assert property (
    cfg_v.sel1 == lic_pkg::LIC_SEL_OFF |=> !ind_on[0]) else $error("forced off lamp lit");
  a_unused_dark: assert property (
    cfg_v.sel2 inside {lic_pkg::LIC_SEL_UNUSED6, lic_pkg::LIC_SEL_UNUSEDF} |=> !ind_on[1])
    else $error("unused code lit lamp");
  a_link_level: assert property (
    cfg_v.sel2 == lic_pkg::LIC_SEL_LINK |=> ind_on[1] == $past(status.link))
    else $error("link lamp wrong");
  a_evt_on: assert property (
    s_rx_evt |=> ind_on[2]) else $error("receive event not shown");
  a_hold_on: assert property (
    rx3 && gap_r != 8'h00 && gap_r <= dur_c + 1 |-> ind_on[2]) else $error("hold too short");
  a_hold_off: assert property (
    rx3 && gap_r == dur_c + 2 |-> !ind_on[2]) else $error("hold too long");
  a_no_stretch: assert property (
    cfg_v.sel3 == lic_pkg::LIC_SEL_RX && !cfg_v.stretch_en && !status.rx |=> !ind_on[2])
    else $error("stretched while disabled");
endmodule

bind lic_top lic_chk #(.STR0_CYC(STR0_CYC), .STR1_CYC(STR1_CYC), .STR2_CYC(STR2_CYC)) u_lic_chk (
  .clk_sys(clk_sys), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
  .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .status(status), .ind_on(ind_on));

// ### sim/lic_lamp.sv
`timescale 1ns/10ps
module lic_lamp (
  input  wire logic clk_sys,
  input  wire logic lamp,
  output int        on_len,
  output int        off_len,
  output int        flips
);
  logic prev = 1'b0;
  int   run  = 0;
  // Lamp only sees clock samples, so run lengths are in cycles
  always @(posedge clk_sys) begin
    if (lamp !== prev) begin
      if (prev) begin
        on_len <= run;
      end else begin
        off_len <= run;
      end
      flips <= flips + 1;
      run = 1;
      prev = lamp;
    end else begin
      run = run + 1;
    end
  end
endmodule

// ### sim/tb_lic_top.sv
`timescale 1ns/10ps
module tb_lic_top;
  localparam int S0 = 20;
  localparam int S1 = 40;
  localparam int S2 = 70;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  mgmt_addr = 5'h00;
  logic        mgmt_wr_en = 1'b0;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata;
  logic [5:0]  st = 6'h00;
  logic [2:0]  ind_on;
  int          bad_count = 0;
  int          checks_done = 0;
  int          f0, f1, f2;
  int          lens[4] = '{S0, S1, S2, S2};
  always #10 clk_sys = ~clk_sys;
  lic_top #(.STR0_CYC(S0), .STR1_CYC(S1), .STR2_CYC(S2), .FAST_BIT(2), .SLOW_BIT(4)) u_lic_top (
    .clk_sys(clk_sys), .rst(rst), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .status(lic_pkg::lic_status_s'(st)), .ind_on(ind_on));
  lic_lamp u_lic_lamp (.clk_sys(clk_sys), .lamp(ind_on[2]), .on_len(), .off_len(), .flips());
  // --------------
  // Bench tasks
  // --------------
  task automatic end_of_test();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr_en = 1'b1;
    cyc(1);
    mgmt_wr_en = 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    mgmt_addr = a;
    cyc(1);
    chk(mgmt_rdata, exp);
  endtask
  task automatic pulse(input logic [5:0] m);
    st = st | m;
    cyc(1);
    st = st & ~m;
  endtask
  // Second pulse lands gap+1 cycles after the first, restarting the hold
  task automatic run_evt(input logic [3:0] sel, input logic [1:0] dur, input logic se,
                         input logic [5:0] m, input int gap);
    wr(5'h14, {8'h04, sel, dur, se, 1'b0});
    cyc(2);
    pulse(m);
    if (gap > 0) begin
      cyc(gap);
      pulse(m);
    end
    cyc(90);
  endtask
  function automatic logic lvl(input logic [3:0] c, input logic [5:0] s);
    case (c)
      4'h0: lvl = s[5];
      4'h4, 4'hc, 4'hd: lvl = s[4];
      4'h5, 4'he: lvl = s[3];
      4'h8: lvl = 1'b1;
      default: lvl = 1'b0;
    endcase
  endfunction
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    cyc(8);
    rst = 1'b0;
    rdc(5'h14, 16'h0422);
    rdc(5'h13, 16'h0000);
    wr(5'h13, 16'hffff);
    rdc(5'h14, 16'h0422);
    wr(5'h14, 16'h8961);
    rdc(5'h14, 16'h8960);
    chk({13'h0, ind_on}, 16'h0001);
    for (int p = 0; p < 2; p++) begin
      st = p ? 6'h10 : 6'h28;
      for (int c = 0; c < 16; c++) begin
        if (c != 10 && c != 11) begin
          wr(5'h14, {c[3:0], c[3:0], c[3:0], 4'h0});
          cyc(2);
          chk({13'h0, ind_on}, {13'h0, {3{lvl(c[3:0], st)}}});
        end
      end
    end
    wr(5'h14, 16'h00a0);
    f0 = u_lic_lamp.flips;
    cyc(64);
    f1 = u_lic_lamp.flips - f0;
    wr(5'h14, 16'h00b0);
    f0 = u_lic_lamp.flips;
    cyc(64);
    f2 = u_lic_lamp.flips - f0;
    chk(16'(f1 > f2 && f2 > 0), 16'h0001);
    st = 6'h00;
    for (int d = 0; d < 4; d++) begin
      run_evt(4'h2, d[1:0], 1'b1, 6'h02, 0);
      chk(16'(u_lic_lamp.on_len), 16'(lens[d] + 1));
    end
    run_evt(4'h1, 2'h0, 1'b1, 6'h04, 0);
    chk(16'(u_lic_lamp.on_len), 16'(S0 + 1));
    run_evt(4'h3, 2'h0, 1'b1, 6'h01, 0);
    chk(16'(u_lic_lamp.on_len), 16'(S0 + 1));
    run_evt(4'h7, 2'h0, 1'b1, 6'h04, 0);
    chk(16'(u_lic_lamp.on_len), 16'(S0 + 1));
    run_evt(4'h2, 2'h0, 1'b1, 6'h02, 10);
    chk(16'(u_lic_lamp.on_len), 16'(S0 + 12));
    run_evt(4'h2, 2'h0, 1'b0, 6'h02, 0);
    chk(16'(u_lic_lamp.on_len), 16'h0001);
    st = 6'h10;
    run_evt(4'hc, 2'h0, 1'b0, 6'h02, 0);
    chk(16'(u_lic_lamp.off_len), 16'(S0 + 1));
    st = 6'h00;
    run_evt(4'hd, 2'h0, 1'b0, 6'h04, 0);
    chk(16'(u_lic_lamp.on_len), 16'(S0 + 1));
    st = 6'h08;
    run_evt(4'he, 2'h0, 1'b0, 6'h01, 0);
    chk(16'(u_lic_lamp.off_len), 16'(S0 + 1));
    end_of_test();
  end
endmodule
